// ---- core/tvm_cfg.svh ----
// Purpose: Constants for the temperature and supply monitor register bank
// Assumes: Included by the package and by every design file that decodes registers
// Notes: Offsets are register indices on the plain 8-bit register port
`ifndef TVM_CFG_SVH
`define TVM_CFG_SVH

`define TVM_ADDR_W 8
`define TVM_DATA_W 8

`define TVM_OFS_TEMP 8'h00
`define TVM_OFS_LV 8'h01

`define TVM_BIT_ROUTE_SEL 5
`define TVM_BIT_SENSOR_EN 3
`define TVM_BIT_STATUS 2
`define TVM_BIT_IRQ_EN 1
`define TVM_BIT_FLAG 0

`define TVM_TEMP_RST 8'h00
`define TVM_LV_RST 8'h00
`define TVM_RDATA_RST 8'h00

`define TVM_SETTLE_CYCLES 3'h4
`define TVM_SETTLE_W 3

`endif

// ---- core/tvm_pkg.sv ----
// Purpose: Types shared by the monitor register bank
// Assumes: Constants come from tvm_cfg.svh
// Notes: Bus request travels as one packed struct
`include "tvm_cfg.svh"

package tvm_pkg;

    typedef struct packed
    {
        logic [`TVM_ADDR_W-1:0] addr;
        logic [`TVM_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } tvm_bus_req_t;

    typedef enum {TVM_ST_SETTLE, TVM_ST_RUN} tvm_state_t;

endpackage : tvm_pkg

// ---- core/tvm_sync.sv ----
// Purpose: Three-stage synchroniser for one comparator level
// Assumes: Input is asynchronous to clk
// Notes: Output follows only when stages two and three agree
`timescale 1ns/100ps

module tvm_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic levelAsync,
    output logic levelSync
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Stage one is read by stage two only, to keep metastability contained
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end
        else
        begin
            stage1 <= levelAsync;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            levelSync <= 1'b0;
        else if (stage2 == stage3)
            levelSync <= stage3;
    end

endmodule : tvm_sync

// ---- core/tvm_flag.sv ----
// Purpose: Sticky change flag with write-one-to-clear and gated request
// Assumes: All inputs are on clk
// Notes: Set wins over a clear in the same cycle; load wins over both
`timescale 1ns/100ps

module tvm_flag
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic setPulse,
    input wire logic clearPulse,
    input wire logic loadPulse,
    input wire logic loadValue,
    input wire logic irqEnable,
    // State out
    output logic flag,
    output logic irq
);

    logic next_flag;

    always_comb
    begin
        next_flag = flag;
        if (loadPulse)
            next_flag = loadValue;
        else if (setPulse)
            next_flag = 1'b1;
        else if (clearPulse)
            next_flag = 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flag <= 1'b0;
        else
            flag <= next_flag;
    end

    // Registered so the request pin is glitch free; it trails the flag by one cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= flag & irqEnable;
    end

endmodule : tvm_flag

// ---- core/tvm_regs.sv ----
// Purpose: Temperature sense and low-supply control/status register bank
// Assumes: 50 MHz clk, asynchronous active-high rst, comparators outside this block
// Notes: Status bits need a short settle after reset before they are trusted
//
// Summary of operation
// - Route-select bit 5 steers converter channel source
// - Sensor enable output follows bit 3
// - Over-temp status bit 2 read-only, mode-qualified
// - Temp change flag sets on status change, W1C
// - Temp request when flag and enable set
// - Temperature register readable, writable bits anytime
// - Low-supply status bit 2 read-only, mode-qualified
// - Low-supply flag sets on status change, W1C
// - Low-supply request when flag and enable set
// - Low-voltage register readable, writable bits anytime
// - Low-supply status and flag reset from level
`timescale 1ns/100ps
`include "tvm_cfg.svh"

module tvm_regs
    import tvm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire tvm_bus_req_t busReq,
    output logic [`TVM_DATA_W-1:0] rdata,
    // Comparators and power mode
    input wire logic overTempRaw,
    input wire logic lowSupplyRaw,
    input wire logic fullPerfMode,
    // Analog control
    output logic voltageRouteSelect,
    output logic tempSensorEnable,
    // Requests
    output logic tempIrq,
    output logic lowSupplyIrq
);

    function automatic logic addrHit(input logic [`TVM_ADDR_W-1:0] addr, input logic [`TVM_ADDR_W-1:0] ofs);
        addrHit = (addr == ofs);
    endfunction : addrHit

    logic wrTemp;
    logic wrLv;
    logic tempIrqEnable;
    logic lowSupplyIrqEnable;
    logic hotSync;
    logic lowSync;
    logic hotNow;
    logic lowNow;
    logic overTempStatus;
    logic lowSupplyStatus;
    logic tempChange;
    logic lowChange;
    logic lvLoad;
    logic tempFlag;
    logic lowFlag;
    logic [`TVM_SETTLE_W-1:0] settleCount;
    tvm_state_t state;
    tvm_state_t next_state;
    logic [`TVM_DATA_W-1:0] tempView;
    logic [`TVM_DATA_W-1:0] lvView;
    logic rdTemp;
    logic rdLv;
    logic clrTemp;
    logic clrLv;
    logic next_voltageRouteSelect;
    logic next_tempSensorEnable;
    logic next_tempIrqEnable;
    logic next_lowSupplyIrqEnable;
    logic next_overTempStatus;
    logic next_lowSupplyStatus;
    logic [`TVM_SETTLE_W-1:0] next_settleCount;
    logic [`TVM_DATA_W-1:0] next_rdata;

    // Reset images, so that each reset bit is picked by its field position
    localparam logic [`TVM_DATA_W-1:0] TEMP_RST = `TVM_TEMP_RST;
    localparam logic [`TVM_DATA_W-1:0] LV_RST = `TVM_LV_RST;

    assign wrTemp = busReq.wr & addrHit(busReq.addr, `TVM_OFS_TEMP);
    assign wrLv = busReq.wr & addrHit(busReq.addr, `TVM_OFS_LV);
    assign rdTemp = busReq.rd & addrHit(busReq.addr, `TVM_OFS_TEMP);
    assign rdLv = busReq.rd & addrHit(busReq.addr, `TVM_OFS_LV);

    // Write-one-to-clear strobes; a zero in the flag position does nothing
    assign clrTemp = wrTemp & busReq.wdata[`TVM_BIT_FLAG];
    assign clrLv = wrLv & busReq.wdata[`TVM_BIT_FLAG];

    // Writable control bits; status bits are never loaded from the bus
    always_comb
    begin
        next_voltageRouteSelect = voltageRouteSelect;
        if (wrTemp)
            next_voltageRouteSelect = busReq.wdata[`TVM_BIT_ROUTE_SEL];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            voltageRouteSelect <= TEMP_RST[`TVM_BIT_ROUTE_SEL];
        else
            voltageRouteSelect <= next_voltageRouteSelect;
    end

    // No interlock with the route bit: raising the enable first is left to software
    always_comb
    begin
        next_tempSensorEnable = tempSensorEnable;
        if (wrTemp)
            next_tempSensorEnable = busReq.wdata[`TVM_BIT_SENSOR_EN];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tempSensorEnable <= TEMP_RST[`TVM_BIT_SENSOR_EN];
        else
            tempSensorEnable <= next_tempSensorEnable;
    end

    always_comb
    begin
        next_tempIrqEnable = tempIrqEnable;
        if (wrTemp)
            next_tempIrqEnable = busReq.wdata[`TVM_BIT_IRQ_EN];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tempIrqEnable <= TEMP_RST[`TVM_BIT_IRQ_EN];
        else
            tempIrqEnable <= next_tempIrqEnable;
    end

    always_comb
    begin
        next_lowSupplyIrqEnable = lowSupplyIrqEnable;
        if (wrLv)
            next_lowSupplyIrqEnable = busReq.wdata[`TVM_BIT_IRQ_EN];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            lowSupplyIrqEnable <= LV_RST[`TVM_BIT_IRQ_EN];
        else
            lowSupplyIrqEnable <= next_lowSupplyIrqEnable;
    end

    // Comparator levels cross into clk here
    tvm_sync hotSyncInst
    (
        .clk(clk),
        .rst(rst),
        .levelAsync(overTempRaw),
        .levelSync(hotSync)
    );

    tvm_sync lowSyncInst
    (
        .clk(clk),
        .rst(rst),
        .levelAsync(lowSupplyRaw),
        .levelSync(lowSync)
    );

    // Reduced performance mode forces both status bits low
    assign hotNow = hotSync & fullPerfMode;
    assign lowNow = lowSync & fullPerfMode;

    // Settle window lets the synchronisers fill before status is believed
    always_comb
    begin
        next_state = state;
        case (state)
            TVM_ST_SETTLE:
            begin
                if (settleCount == `TVM_SETTLE_CYCLES)
                    next_state = TVM_ST_RUN;
            end
            TVM_ST_RUN:
            begin
                next_state = TVM_ST_RUN;
            end
            default:
            begin
                next_state = TVM_ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state <= TVM_ST_SETTLE;
        else
            state <= next_state;
    end

    // Counter holds once running; it is only needed once after each reset
    always_comb
    begin
        next_settleCount = settleCount;
        if (state == TVM_ST_SETTLE)
            next_settleCount = settleCount + `TVM_SETTLE_W'(1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            settleCount <= '0;
        else
            settleCount <= next_settleCount;
    end

    // Low-supply status and flag are taken from the qualified level at the end of settle
    assign lvLoad = (state == TVM_ST_SETTLE) && (next_state == TVM_ST_RUN);

    assign tempChange = (state == TVM_ST_RUN) && (hotNow != overTempStatus);
    assign lowChange = (state == TVM_ST_RUN) && (lowNow != lowSupplyStatus);

    // Status follows the qualified level only on a detected change
    always_comb
    begin
        next_overTempStatus = overTempStatus;
        if (tempChange)
            next_overTempStatus = hotNow;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            overTempStatus <= TEMP_RST[`TVM_BIT_STATUS];
        else
            overTempStatus <= next_overTempStatus;
    end

    // Load and change cannot meet, since change detection waits for the run state
    always_comb
    begin
        next_lowSupplyStatus = lowSupplyStatus;
        if (lvLoad)
            next_lowSupplyStatus = lowNow;
        else if (lowChange)
            next_lowSupplyStatus = lowNow;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            lowSupplyStatus <= LV_RST[`TVM_BIT_STATUS];
        else
            lowSupplyStatus <= next_lowSupplyStatus;
    end

    tvm_flag tempFlagInst
    (
        .clk(clk),
        .rst(rst),
        .setPulse(tempChange),
        .clearPulse(clrTemp),
        .loadPulse(1'b0),
        .loadValue(1'b0),
        .irqEnable(tempIrqEnable),
        .flag(tempFlag),
        .irq(tempIrq)
    );

    tvm_flag lowFlagInst
    (
        .clk(clk),
        .rst(rst),
        .setPulse(lowChange),
        .clearPulse(clrLv),
        .loadPulse(lvLoad),
        .loadValue(lowNow),
        .irqEnable(lowSupplyIrqEnable),
        .flag(lowFlag),
        .irq(lowSupplyIrq)
    );

    always_comb
    begin
        tempView = '0;
        tempView[`TVM_BIT_ROUTE_SEL] = voltageRouteSelect;
        tempView[`TVM_BIT_SENSOR_EN] = tempSensorEnable;
        tempView[`TVM_BIT_STATUS] = overTempStatus;
        tempView[`TVM_BIT_IRQ_EN] = tempIrqEnable;
        tempView[`TVM_BIT_FLAG] = tempFlag;
    end

    always_comb
    begin
        lvView = '0;
        lvView[`TVM_BIT_STATUS] = lowSupplyStatus;
        lvView[`TVM_BIT_IRQ_EN] = lowSupplyIrqEnable;
        lvView[`TVM_BIT_FLAG] = lowFlag;
    end

    // Read data stand one cycle only; unmapped reads return zero
    always_comb
    begin
        next_rdata = `TVM_RDATA_RST;
        if (rdTemp)
            next_rdata = tempView;
        else if (rdLv)
            next_rdata = lvView;
    end

    // Registered so the read port never shows a half-decoded value
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= `TVM_RDATA_RST;
        else
            rdata <= next_rdata;
    end

endmodule : tvm_regs

// ---- dv/tvm_regs_monitor.sv ----
// Purpose: Port checker for the monitor register bank
// Assumes: Bound to tvm_regs, one clock domain
// Notes: Flags are hidden, so checks tie requests to read data
`timescale 1ns/100ps
`include "tvm_cfg.svh"

module tvm_regs_monitor
    import tvm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire tvm_bus_req_t busReq,
    input wire logic [`TVM_DATA_W-1:0] rdata,
    // Comparator side
    input wire logic overTempRaw,
    input wire logic lowSupplyRaw,
    input wire logic fullPerfMode,
    // Outputs
    input wire logic voltageRouteSelect,
    input wire logic tempSensorEnable,
    input wire logic tempIrq,
    input wire logic lowSupplyIrq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire tWr = busReq.wr && busReq.addr == `TVM_OFS_TEMP;
    wire tRd = busReq.rd && busReq.addr == `TVM_OFS_TEMP;
    wire lRd = busReq.rd && busReq.addr == `TVM_OFS_LV;

    property p_route; tWr |=> voltageRouteSelect == $past(busReq.wdata[5]); endproperty
    a_route: assert property (p_route) else $error("route select not loaded");
    property p_enable; tWr |=> tempSensorEnable == $past(busReq.wdata[3]); endproperty
    a_enable: assert property (p_enable) else $error("sensor enable not loaded");
    property p_tIrqOff; tWr && !busReq.wdata[1] |=> ##1 !tempIrq; endproperty
    a_tIrqOff: assert property (p_tIrqOff) else $error("temp request while disabled");
    property p_tIrqRd; tRd |=> tempIrq == (rdata[0] && rdata[1]); endproperty
    a_tIrqRd: assert property (p_tIrqRd) else $error("temp request differs from flag");
    property p_lIrqRd; lRd |=> lowSupplyIrq == (rdata[0] && rdata[1]); endproperty
    a_lIrqRd: assert property (p_lIrqRd) else $error("low request differs from flag");
    property p_tFields; tRd |=> rdata[7:6] == 2'h0 && rdata[5] == voltageRouteSelect && !rdata[4]; endproperty
    a_tFields: assert property (p_tFields) else $error("temp register read wrong");
    property p_lFields; lRd |=> rdata[7:3] == 5'h00; endproperty
    a_lFields: assert property (p_lFields) else $error("low register upper bits set");
    property p_rpm; !fullPerfMode ##1 (!fullPerfMode && busReq.rd && busReq.addr <= 8'h01) |=> !rdata[2]; endproperty
    a_rpm: assert property (p_rpm) else $error("status set in reduced mode");
    property p_idle; !busReq.rd |=> rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read slot");
endmodule : tvm_regs_monitor

bind tvm_regs tvm_regs_monitor u_mon (.clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata),
    .overTempRaw(overTempRaw), .lowSupplyRaw(lowSupplyRaw), .fullPerfMode(fullPerfMode),
    .voltageRouteSelect(voltageRouteSelect), .tempSensorEnable(tempSensorEnable),
    .tempIrq(tempIrq), .lowSupplyIrq(lowSupplyIrq));

// ---- dv/tvm_comp_model.sv ----
// Purpose: Behavioural comparators and power mode source
// Assumes: Requests come from the bench
// Notes: Comparator edges land off the clock grid
`timescale 1ns/100ps

module tvm_comp_model
(
    // Requests
    input wire logic hotReq,
    input wire logic lowReq,
    input wire logic perfReq,
    // Levels
    output logic overTempRaw,
    output logic lowSupplyRaw,
    output logic fullPerfMode
);
    // Analog outputs are asynchronous, so they move mid-cycle
    assign #7 overTempRaw = hotReq;
    assign #13 lowSupplyRaw = lowReq;
    assign fullPerfMode = perfReq;
endmodule : tvm_comp_model

// ---- dv/tvm_regs_tb.sv ----
// Purpose: Self-checking bench for the monitor register bank
// Assumes: 50 MHz clock, register port one-cycle strobes
// Notes: Flags are observed through reads and requests
`timescale 1ns/100ps

module tvm_regs_tb import tvm_pkg::*;;
    logic clk;
    logic rst = 1'b1;
    tvm_bus_req_t busReq = '0;
    logic [7:0] rdata;
    logic hotReq = 1'b0;
    logic lowReq = 1'b1;
    logic perfReq = 1'b1;
    logic overTempRaw, lowSupplyRaw, fullPerfMode, voltageRouteSelect, tempSensorEnable, tempIrq, lowSupplyIrq;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    tvm_comp_model comp (.hotReq(hotReq), .lowReq(lowReq), .perfReq(perfReq), .overTempRaw(overTempRaw),
        .lowSupplyRaw(lowSupplyRaw), .fullPerfMode(fullPerfMode));
    tvm_regs DUT (.clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata), .overTempRaw(overTempRaw),
        .lowSupplyRaw(lowSupplyRaw), .fullPerfMode(fullPerfMode), .voltageRouteSelect(voltageRouteSelect),
        .tempSensorEnable(tempSensorEnable), .tempIrq(tempIrq), .lowSupplyIrq(lowSupplyIrq));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task summarize;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask : rd

    task irqs(input logic t, input logic l);
        repeat (2) @(posedge clk);
        #1;
        chk("requests", {6'h0, t, l}, {6'h0, tempIrq, lowSupplyIrq});
    endtask : irqs

    task outs(input logic r, input logic e);
        #1;
        chk("analog", {6'h0, r, e}, {6'h0, voltageRouteSelect, tempSensorEnable});
    endtask : outs

    task settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1500)
        begin
            n_errors++;
            summarize();
        end
    end

    initial
    begin
        settle(20);
        rst <= 1'b0;
        settle(10);
        rd(8'h01, 8'h05);
        wr(8'h01, 8'h02);
        irqs(1'b0, 1'b1);
        wr(8'h01, 8'h03);
        rd(8'h01, 8'h06);
        irqs(1'b0, 1'b0);
        lowReq <= 1'b0;
        settle(10);
        rd(8'h01, 8'h03);
        irqs(1'b0, 1'b1);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h01);
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h00);
        // Sensor goes on in the same write as the route bit, not before it
        wr(8'h00, 8'h28);
        outs(1'b1, 1'b1);
        rd(8'h00, 8'h28);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h2a);
        hotReq <= 1'b1;
        settle(10);
        rd(8'h00, 8'h2f);
        irqs(1'b1, 1'b0);
        wr(8'h00, 8'h2e);
        rd(8'h00, 8'h2f);
        wr(8'h00, 8'h2b);
        rd(8'h00, 8'h2e);
        irqs(1'b0, 1'b0);
        wr(8'h00, 8'h08);
        outs(1'b0, 1'b1);
        perfReq <= 1'b0;
        lowReq <= 1'b1;
        settle(10);
        rd(8'h00, 8'h09);
        rd(8'h01, 8'h01);
        irqs(1'b0, 1'b0);
        rst <= 1'b1;
        settle(3);
        rst <= 1'b0;
        settle(10);
        rd(8'h01, 8'h00);
        rd(8'h00, 8'h00);
        summarize();
    end
endmodule : tvm_regs_tb
